// ==== rtl/access_track_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface access_track_if;
    import meter_map_pkg::*;
    logic commit;
    logic isWrite;
    logic [15:0] addr;
    fmt_t fmt;
    logic [31:0] data;
    logic [15:0] lastAddr;
    logic [15:0] lastHalf;
    logic [7:0] lastByte;
    logic [7:0] lastKind;
    modport owner (output commit, isWrite, addr, fmt, data,
        input lastAddr, lastHalf, lastByte, lastKind);
    modport tracker (input commit, isWrite, addr, fmt, data,
        output lastAddr, lastHalf, lastByte, lastKind);
endinterface: access_track_if
`default_nettype wire

// ==== rtl/last_access_tracker.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "meter_map_defines.svh"
module last_access_tracker (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // access events
    access_track_if.tracker trk
);
    import meter_map_pkg::*;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trk.lastAddr <= 16'h0000;
            trk.lastKind <= 8'h00;
        end else if (trk.commit) begin
            trk.lastAddr <= trk.addr;
            trk.lastKind <= trk.isWrite ? `KIND_WRITE : `KIND_READ;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trk.lastHalf <= 16'h0000;
            trk.lastByte <= 8'h00;
        end else if (trk.commit) begin
            if (trk.fmt == FMT_16 || trk.fmt == FMT_16ZP) begin
                trk.lastHalf <= trk.data[15:0];
            end
            if (trk.fmt == FMT_8) begin
                trk.lastByte <= trk.data[7:0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_addr_cap;
        trk.commit |=> trk.lastAddr == $past(trk.addr);
    endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("last address not captured");
    property p_half_cap;
        trk.commit && trk.fmt == FMT_16 |=> trk.lastHalf == $past(trk.data[15:0]);
    endproperty
    a_half_cap: assert property (p_half_cap) else $error("halfword not captured");
    property p_byte_cap;
        trk.commit && trk.fmt == FMT_8 |=> trk.lastByte == $past(trk.data[7:0]);
    endproperty
    a_byte_cap: assert property (p_byte_cap) else $error("byte not captured");
    property p_kind;
        trk.commit && trk.isWrite |=> trk.lastKind == `KIND_WRITE;
    endproperty
    a_kind: assert property (p_kind) else $error("write kind wrong");
    property p_hold;
        !trk.commit |=> $stable(trk.lastAddr) && $stable(trk.lastKind) && $stable(trk.lastHalf);
    endproperty
    a_hold: assert property (p_hold) else $error("tracking changed without commit");
endmodule: last_access_tracker
`default_nettype wire

// ==== rtl/meter_map_defines.svh ====
`ifndef METER_MAP_DEFINES_SVH
`define METER_MAP_DEFINES_SVH
// Operation
// - keep address of last successful access.
// - capture data of each 16-bit transfer.
// - capture data of each 8-bit transfer.
// - record whether last access was read/write.
// - slot address drives select pin under SPI.
// - 10-bit registers sent with six zero MSBs.
// - 24/20-bit registers zero padded to 32.
// - 24-bit signed registers sign extended to 32.
// - signed is two's complement, unsigned binary.
// - read-only ignores writes; read/write accepts both.
// - phase B/C trims: 10-bit, signed, reset zero.
// - pulse latch interval count resets to one.
// - peak and sag windows reset to zero.
// - line accumulation 0x78, measurement setup 0x1C.
// - overcurrent level resets to 0x07.
// - sleep mode one setup resets to zero.
`define ADDR_PHB_TRIM 16'he615
`define ADDR_PHC_TRIM 16'he616
`define ADDR_POLARITY 16'he617
`define ADDR_SETUP_WORD 16'he618
`define ADDR_RSVD0_LO 16'he619
`define ADDR_RSVD0_HI 16'he6fd
`define ADDR_LAST_LOC 16'he6fe
`define ADDR_LAST_HALF 16'he6ff
`define ADDR_MEAS 16'he700
`define ADDR_ACCUM 16'he701
`define ADDR_LINE 16'he702
`define ADDR_PEAK 16'he703
`define ADDR_SAG 16'he704
`define ADDR_PULSE 16'he705
`define ADDR_CAPTURE 16'he706
`define ADDR_REVISION 16'he707
`define ADDR_RSVD1_LO 16'he708
`define ADDR_RSVD1_HI 16'he73f
`define ADDR_FILTER 16'he740
`define ADDR_RSVD2_LO 16'he741
`define ADDR_RSVD2_HI 16'he7fb
`define ADDR_LAST_BYTE 16'he7fc
`define ADDR_LAST_KIND 16'he7fd
`define ADDR_SEL_SLOT 16'hebff
`define ADDR_OC_LEVEL 16'hec00
`define ADDR_SLEEP1 16'hec01
`define RST_TRIM 10'h000
`define RST_SETUP_WORD 16'h0000
`define RST_MEAS 8'h1c
`define RST_ACCUM 8'h00
`define RST_LINE 8'h78
`define RST_PEAK 8'h00
`define RST_SAG 8'h00
`define RST_PULSE 8'h01
`define RST_CAPTURE 8'h00
`define RST_FILTER 8'h00
`define RST_OC_LEVEL 8'h07
`define RST_SLEEP1 8'h00
`define KIND_READ 8'h35
`define KIND_WRITE 8'hca
`define SEL_LEVEL_BIT 0
`define SEL_DRIVE_BIT 1
`endif

// ==== rtl/meter_map_pkg.sv ====
package meter_map_pkg;
    typedef enum logic [5:0] {
        FMT_8 = 6'h01,
        FMT_16 = 6'h02,
        FMT_16ZP = 6'h04,
        FMT_32ZP24 = 6'h08,
        FMT_32ZP20 = 6'h10,
        FMT_32SE = 6'h20
    } fmt_t;

    function automatic logic [31:0] pad_value(input fmt_t f, input logic [23:0] v);
        logic [31:0] r;
        r = 32'h0;
        case (f)
            FMT_8: r = {24'h0, v[7:0]};
            FMT_16: r = {16'h0, v[15:0]};
            FMT_16ZP: r = {22'h0, v[9:0]};
            FMT_32ZP24: r = {8'h0, v};
            FMT_32ZP20: r = {12'h0, v[19:0]};
            FMT_32SE: r = {{8{v[23]}}, v};
            default: r = 32'h0;
        endcase
        return r;
    endfunction: pad_value
endpackage: meter_map_pkg

// ==== rtl/meter_register_map_tail.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "meter_map_defines.svh"
module meter_register_map_tail #(
    // arbitrary neutral value
    parameter logic [7:0] DIE_REVISION = 8'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register access
    input wire logic accStrobe,
    input wire logic accWrite,
    input wire logic accAbort,
    input wire logic [15:0] accAddr,
    input wire logic [31:0] accWdata,
    // read answer
    output logic rdValid,
    output logic [31:0] rdData,
    output meter_map_pkg::fmt_t rdFormat,
    // lower bank pass-through
    input wire logic lowerHit,
    input wire logic [23:0] lowerData,
    input wire meter_map_pkg::fmt_t lowerFormat,
    // device state
    input wire logic [15:0] powerSign,
    input wire logic spiActive,
    // configuration out
    output logic [9:0] phaseBTrim,
    output logic [9:0] phaseCTrim,
    output logic [15:0] setupWord,
    output logic [7:0] measSetup,
    output logic [7:0] accumSetup,
    output logic [7:0] lineAccum,
    output logic [7:0] peakWindow,
    output logic [7:0] sagWindow,
    output logic [7:0] pulseInterval,
    output logic [7:0] captureSetup,
    output logic [7:0] filterSetup,
    output logic [7:0] ocLevel,
    output logic [7:0] sleepOneSetup,
    // select or capture active pin
    output logic selPinOut,
    output logic selPinOe
);
    import meter_map_pkg::*;

    logic wrOk;
    logic rdOk;
    logic mapHit;
    logic rsvdHit;
    logic [23:0] rawValue;
    fmt_t curFmt;
    logic [31:0] xferValue;
    logic selLevel;
    logic selDrive;

    access_track_if trk ();

    assign wrOk = accStrobe && accWrite && !accAbort;
    assign rdOk = accStrobe && !accWrite && !accAbort;

    function automatic logic hitWr(input logic [15:0] a);
        return wrOk && accAddr == a;
    endfunction: hitWr

    assign rsvdHit = (accAddr >= `ADDR_RSVD0_LO && accAddr <= `ADDR_RSVD0_HI)
        || (accAddr >= `ADDR_RSVD1_LO && accAddr <= `ADDR_RSVD1_HI)
        || (accAddr >= `ADDR_RSVD2_LO && accAddr <= `ADDR_RSVD2_HI);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phaseBTrim <= `RST_TRIM;
        end else if (hitWr(`ADDR_PHB_TRIM)) begin
            phaseBTrim <= accWdata[9:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            phaseCTrim <= `RST_TRIM;
        end else if (hitWr(`ADDR_PHC_TRIM)) begin
            phaseCTrim <= accWdata[9:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            setupWord <= `RST_SETUP_WORD;
        end else if (hitWr(`ADDR_SETUP_WORD)) begin
            setupWord <= accWdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            measSetup <= `RST_MEAS;
        end else if (hitWr(`ADDR_MEAS)) begin
            measSetup <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            accumSetup <= `RST_ACCUM;
        end else if (hitWr(`ADDR_ACCUM)) begin
            accumSetup <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lineAccum <= `RST_LINE;
        end else if (hitWr(`ADDR_LINE)) begin
            lineAccum <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            peakWindow <= `RST_PEAK;
        end else if (hitWr(`ADDR_PEAK)) begin
            peakWindow <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sagWindow <= `RST_SAG;
        end else if (hitWr(`ADDR_SAG)) begin
            sagWindow <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pulseInterval <= `RST_PULSE;
        end else if (hitWr(`ADDR_PULSE)) begin
            pulseInterval <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            captureSetup <= `RST_CAPTURE;
        end else if (hitWr(`ADDR_CAPTURE)) begin
            captureSetup <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            filterSetup <= `RST_FILTER;
        end else if (hitWr(`ADDR_FILTER)) begin
            filterSetup <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ocLevel <= `RST_OC_LEVEL;
        end else if (hitWr(`ADDR_OC_LEVEL)) begin
            ocLevel <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sleepOneSetup <= `RST_SLEEP1;
        end else if (hitWr(`ADDR_SLEEP1)) begin
            sleepOneSetup <= accWdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            selLevel <= 1'b1;
            selDrive <= 1'b0;
        end else if (hitWr(`ADDR_SEL_SLOT) && spiActive) begin
            selLevel <= accWdata[`SEL_LEVEL_BIT];
            selDrive <= accWdata[`SEL_DRIVE_BIT];
        end
    end

    // pin released whenever another port owns it
    assign selPinOut = selLevel;
    assign selPinOe = selDrive && spiActive;

    always_comb begin
        rawValue = 24'h0;
        curFmt = FMT_8;
        mapHit = 1'b1;
        case (accAddr)
            `ADDR_PHB_TRIM: begin
                rawValue = {14'h0, phaseBTrim};
                curFmt = FMT_16ZP;
            end
            `ADDR_PHC_TRIM: begin
                rawValue = {14'h0, phaseCTrim};
                curFmt = FMT_16ZP;
            end
            `ADDR_POLARITY: begin
                rawValue = {8'h0, powerSign};
                curFmt = FMT_16;
            end
            `ADDR_SETUP_WORD: begin
                rawValue = {8'h0, setupWord};
                curFmt = FMT_16;
            end
            `ADDR_LAST_LOC: begin
                rawValue = {8'h0, trk.lastAddr};
                curFmt = FMT_16;
            end
            `ADDR_LAST_HALF: begin
                rawValue = {8'h0, trk.lastHalf};
                curFmt = FMT_16;
            end
            `ADDR_MEAS: rawValue = {16'h0, measSetup};
            `ADDR_ACCUM: rawValue = {16'h0, accumSetup};
            `ADDR_LINE: rawValue = {16'h0, lineAccum};
            `ADDR_PEAK: rawValue = {16'h0, peakWindow};
            `ADDR_SAG: rawValue = {16'h0, sagWindow};
            `ADDR_PULSE: rawValue = {16'h0, pulseInterval};
            `ADDR_CAPTURE: rawValue = {16'h0, captureSetup};
            `ADDR_REVISION: rawValue = {16'h0, DIE_REVISION};
            `ADDR_FILTER: rawValue = {16'h0, filterSetup};
            `ADDR_LAST_BYTE: rawValue = {16'h0, trk.lastByte};
            `ADDR_LAST_KIND: rawValue = {16'h0, trk.lastKind};
            `ADDR_SEL_SLOT: rawValue = 24'h0;
            `ADDR_OC_LEVEL: rawValue = {16'h0, ocLevel};
            `ADDR_SLEEP1: rawValue = {16'h0, sleepOneSetup};
            default: begin
                // lower range is answered from outside
                mapHit = 1'b0;
                rawValue = lowerHit ? lowerData : 24'h0;
                curFmt = lowerHit ? lowerFormat : FMT_8;
            end
        endcase
    end

    always_comb begin
        if (accWrite) begin
            xferValue = pad_value(curFmt, accWdata[23:0]);
        end else begin
            xferValue = pad_value(curFmt, rawValue);
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdValid <= 1'b0;
            rdData <= 32'h0;
            rdFormat <= FMT_8;
        end else begin
            rdValid <= rdOk;
            if (rdOk) begin
                rdData <= xferValue;
                rdFormat <= curFmt;
            end
        end
    end

    assign trk.commit = accStrobe && !accAbort && (mapHit || lowerHit) && !rsvdHit;
    assign trk.isWrite = accWrite;
    assign trk.addr = accAddr;
    assign trk.fmt = curFmt;
    assign trk.data = xferValue;

    last_access_tracker u_tracker (
        .clk(clk),
        .rstn(rstn),
        .trk(trk)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_trim_pad;
        rdOk && accAddr == `ADDR_PHB_TRIM |=> rdValid && rdData[31:10] == 22'h0
            && rdData[9:0] == phaseBTrim;
    endproperty
    a_trim_pad: assert property (p_trim_pad) else $error("trim read not zero padded");

    property p_zp20;
        rdValid && rdFormat == FMT_32ZP20 |-> rdData[31:20] == 12'h0;
    endproperty
    a_zp20: assert property (p_zp20) else $error("20-bit read not padded");

    property p_sign_ext;
        rdOk && curFmt == FMT_32SE |=> rdData[31:24] == {8{rdData[23]}};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extension wrong");

    // written out in full: a function body would see post-edge values
    property p_trim_write;
        wrOk && accAddr == `ADDR_PHC_TRIM |=> phaseCTrim == $past(accWdata[9:0]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write lost");

    property p_rsvd_quiet;
        accStrobe && rsvdHit |-> !trk.commit ##1 $stable(measSetup) && $stable(setupWord);
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet) else $error("reserved write had effect");

    property p_reset_vals;
        $rose(rstn) |-> measSetup == `RST_MEAS && lineAccum == `RST_LINE
            && pulseInterval == `RST_PULSE && peakWindow == `RST_PEAK;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset value wrong");

    property p_lp_reset;
        $rose(rstn) |-> ocLevel == `RST_OC_LEVEL && sleepOneSetup == `RST_SLEEP1;
    endproperty
    a_lp_reset: assert property (p_lp_reset) else $error("low power reset wrong");

    // enable may drop at once if the port changes hands
    property p_sel_pin;
        wrOk && accAddr == `ADDR_SEL_SLOT && spiActive
            |=> selPinOe == ($past(accWdata[`SEL_DRIVE_BIT]) && spiActive)
            && selPinOut == $past(accWdata[`SEL_LEVEL_BIT]);
    endproperty
    a_sel_pin: assert property (p_sel_pin) else $error("select pin not steered");

    property p_abort;
        accStrobe && accAbort |=> !rdValid && $stable(trk.lastAddr);
    endproperty
    a_abort: assert property (p_abort) else $error("aborted transfer had effect");

    c_trim_wr: cover property (wrOk && accAddr == `ADDR_PHB_TRIM ##2 rdOk);
    c_abort: cover property (accStrobe && accAbort);
    c_sel_pin: cover property (wrOk && accAddr == `ADDR_SEL_SLOT && spiActive);
    c_wide_rd: cover property (rdOk && lowerHit && curFmt == FMT_32SE);
endmodule: meter_register_map_tail
`default_nettype wire

// ==== verification/host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // clock
    input wire logic clk,
    // register access
    output logic accStrobe,
    output logic accWrite,
    output logic accAbort,
    output logic [15:0] accAddr,
    output logic [31:0] accWdata,
    // read answer
    input wire logic rdValid,
    input wire logic [31:0] rdData
);
    initial begin
        accStrobe = 1'b0;
        accWrite = 1'b0;
        accAbort = 1'b0;
        accAddr = 16'h0000;
        accWdata = 32'h0;
    end

    // callers also read a reserved range and write the slot without SPI
    task automatic xfer(input logic wr, input logic ab, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int i;
        @(posedge clk);
        accStrobe <= 1'b1;
        accWrite <= wr;
        accAbort <= ab;
        accAddr <= a;
        accWdata <= d;
        @(posedge clk);
        accStrobe <= 1'b0;
        // released lines stop showing the last value
        accAddr <= ~a;
        accWdata <= ~d;
        q = 32'hx;
        ok = wr | ab;
        #1;
        for (i = 0; i < 3 && !ok; i++) begin
            if (rdValid === 1'b1) begin
                q = rdData;
                ok = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask: xfer
endmodule: host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "meter_map_defines.svh"
module tb_top;
    import meter_map_pkg::*;
    localparam logic [7:0] REV = 8'h3c;
    localparam logic [15:0] RA[13] = '{16'he615, 16'he616, 16'he618, 16'he700, 16'he701,
        16'he702, 16'he703, 16'he704, 16'he705, 16'he706, 16'he740, 16'hec00, 16'hec01};
    localparam logic [31:0] RV[13] = '{32'h0, 32'h0, 32'h0, 32'h1c, 32'h0, 32'h78, 32'h0,
        32'h0, 32'h01, 32'h0, 32'h0, 32'h07, 32'h0};
    logic clk = 1'b0;
    logic rstn, accStrobe, accWrite, accAbort, rdValid, lowerHit, spiActive, selPinOut, selPinOe;
    logic [15:0] accAddr, powerSign, setupWord;
    logic [31:0] accWdata, rdData;
    logic [23:0] lowerData;
    fmt_t rdFormat, lowerFormat;
    logic [9:0] phaseBTrim, phaseCTrim;
    logic [7:0] measSetup, accumSetup, lineAccum, peakWindow, sagWindow, pulseInterval;
    logic [7:0] captureSetup, filterSetup, ocLevel, sleepOneSetup;
    int errors = 0;
    int nCompared = 0;

    always #10 clk = ~clk;

    meter_register_map_tail #(.DIE_REVISION(REV)) dut (.clk, .rstn, .accStrobe, .accWrite,
        .accAbort, .accAddr, .accWdata, .rdValid, .rdData, .rdFormat, .lowerHit, .lowerData,
        .lowerFormat, .powerSign, .spiActive, .phaseBTrim, .phaseCTrim, .setupWord,
        .measSetup, .accumSetup, .lineAccum, .peakWindow, .sagWindow, .pulseInterval,
        .captureSetup, .filterSetup, .ocLevel, .sleepOneSetup, .selPinOut, .selPinOe);
    host_model host (.clk, .accStrobe, .accWrite, .accAbort, .accAddr, .accWdata,
        .rdValid, .rdData);

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask: finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask: chk

    task automatic go(input logic wr, input logic ab, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] q);
        logic ok;
        host.xfer(wr, ab, a, d, q, ok);
        if (!ok) begin
            errors++;
            $display("MISMATCH read answer of %h expected 1 seen 0", a);
            finish_test();
        end
    endtask: go

    task automatic rdchk(input string what, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] q;
        go(1'b0, 1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask: rdchk

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        go(1'b1, 1'b0, a, d, q);
    endtask: wr

    task automatic t_reset();
        chk("line out", 32'h78, {24'h0, lineAccum});
        chk("meas out", 32'h1c, {24'h0, measSetup});
        chk("pulse out", 32'h01, {24'h0, pulseInterval});
        chk("oc out", 32'h07, {24'h0, ocLevel});
        chk("sel pin", 32'h1, {30'h0, selPinOe, selPinOut});
        foreach (RA[i]) rdchk("reset read", RA[i], RV[i]);
        $display("reset values done");
    endtask: t_reset

    task automatic t_trim();
        wr(16'he615, 32'h3ff);
        chk("trim b out", 32'h3ff, {22'h0, phaseBTrim});
        rdchk("trim b read", 16'he615, 32'h3ff);
        chk("trim format", {26'h0, FMT_16ZP}, {26'h0, rdFormat});
        wr(16'he616, 32'hffff_fe00);
        chk("trim c out", 32'h200, {22'h0, phaseCTrim});
        rdchk("trim c read", 16'he616, 32'h200);
        wr(16'he703, 32'h44);
        chk("peak out", 32'h44, {24'h0, peakWindow});
        rdchk("peak read", 16'he703, 32'h44);
        wr(16'he706, 32'h66);
        wr(16'he740, 32'h77);
        wr(16'hec01, 32'h88);
        chk("capture out", 32'h66, {24'h0, captureSetup});
        chk("filter out", 32'h77, {24'h0, filterSetup});
        chk("sleep1 out", 32'h88, {24'h0, sleepOneSetup});
        $display("trim test done");
    endtask: t_trim

    task automatic t_readonly();
        @(posedge clk);
        powerSign <= 16'h8421;
        wr(16'he617, 32'hffff);
        rdchk("polarity", 16'he617, 32'h8421);
        wr(16'he707, 32'h55);
        rdchk("revision", 16'he707, {24'h0, REV});
        rdchk("reserved read", 16'he650, 32'h0);
        $display("read-only test done");
    endtask: t_readonly

    task automatic t_track();
        wr(16'he700, 32'h5a);
        rdchk("last addr", 16'he6fe, 32'he700);
        rdchk("last byte", 16'he7fc, 32'h5a);
        wr(16'he618, 32'hbeef);
        chk("setup word out", 32'hbeef, {16'h0, setupWord});
        rdchk("last half", 16'he6ff, 32'hbeef);
        rdchk("kind read", 16'he7fd, 32'h35);
        wr(16'he701, 32'h11);
        chk("accum out", 32'h11, {24'h0, accumSetup});
        rdchk("kind write", 16'he7fd, 32'hca);
        $display("tracking test done");
    endtask: t_track

    task automatic t_abort();
        logic [31:0] q;
        go(1'b1, 1'b1, 16'he704, 32'h99, q);
        chk("sag out", 32'h0, {24'h0, sagWindow});
        rdchk("addr after abort", 16'he6fe, 32'he7fd);
        $display("abort test done");
    endtask: t_abort

    task automatic t_lower();
        fmt_t f[3];
        logic [31:0] e[3];
        f = '{FMT_32ZP24, FMT_32ZP20, FMT_32SE};
        e = '{32'h008a_bcde, 32'h000a_bcde, 32'hff8a_bcde};
        foreach (f[i]) begin
            @(posedge clk);
            lowerHit <= 1'b1;
            lowerData <= 24'h8abcde;
            lowerFormat <= f[i];
            rdchk("lower pad", 16'h4380, e[i]);
        end
        @(posedge clk);
        lowerHit <= 1'b0;
        $display("padding test done");
    endtask: t_lower

    task automatic t_sel();
        @(posedge clk);
        spiActive <= 1'b1;
        wr(16'hebff, 32'h2);
        chk("sel 2", 32'h2, {30'h0, selPinOe, selPinOut});
        wr(16'hebff, 32'h3);
        chk("sel 3", 32'h3, {30'h0, selPinOe, selPinOut});
        @(posedge clk);
        spiActive <= 1'b0;
        @(posedge clk);
        #1;
        chk("sel off", 32'h0, {31'h0, selPinOe});
        wr(16'hebff, 32'h0);
        @(posedge clk);
        spiActive <= 1'b1;
        @(posedge clk);
        #1;
        chk("sel kept", 32'h3, {30'h0, selPinOe, selPinOut});
        $display("select pin test done");
    endtask: t_sel

    initial begin
        rstn = 1'b0;
        lowerHit = 1'b0;
        lowerData = 24'h0;
        lowerFormat = FMT_8;
        powerSign = 16'h0;
        spiActive = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_trim();
        t_readonly();
        t_track();
        t_abort();
        t_lower();
        t_sel();
        finish_test();
    end
endmodule: tb_top
`default_nettype wire
